// ### src/ocotl_pkg.sv
package ocotl_pkg;
	// command codes of this block
	localparam logic [7:0]  CMD_ACTION     = 8'h47;
	localparam logic [7:0]  CMD_WARN       = 8'h4a;
	localparam logic [7:0]  CMD_TEMP       = 8'h4f;
	localparam logic [7:0]  PHASE_ALL      = 8'hff;
	// field positions
	localparam int          RESP_MSB       = 7;
	localparam int          RESP_LSB       = 6;
	localparam int          RETRY_MSB      = 5;
	localparam int          RETRY_LSB      = 3;
	localparam int          DELAY_MSB      = 2;
	localparam int          DELAY_LSB      = 0;
	localparam int          EXP_MSB        = 15;
	localparam int          EXP_LSB        = 11;
	localparam int          MAN_MSB        = 10;
	// reset values
	localparam logic [7:0]  ACTION_RST     = 8'hc0;
	localparam logic [4:0]  WARN_EXP_RST   = 5'h1e;
	localparam logic [10:0] WARN_MAN_RST   = 11'h0a0;
	localparam logic [4:0]  TEMP_EXP_RST   = 5'h00;
	localparam logic [10:0] TEMP_MAN_RST   = 11'h07d;
	// response and retry codes
	localparam logic [1:0]  RESP_DELAYED   = 2'h2;
	localparam logic [1:0]  RESP_IMMED     = 2'h3;
	localparam logic [2:0]  RETRY_NONE     = 3'h0;
	localparam logic [2:0]  RETRY_FOREVER  = 3'h7;
	// shutdown delays in switching clock periods
	localparam logic [2:0]  DLY_SHORT      = 3'h1;
	localparam logic [2:0]  DLY_MID        = 3'h3;
	localparam logic [2:0]  DLY_LONG       = 3'h7;
	// current limits, quarter amperes and amperes
	localparam int          WARN_MAX_Q     = 'h0f8;
	localparam logic [5:0]  HW_MIN_A       = 6'h08;
	localparam logic [5:0]  HW_MAX_A       = 6'h3e;
	// temperature limits, degrees
	localparam int          TEMP_MAX       = 'h0ff;
	localparam int          TEMP_MIN       = -'h028;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_START  = 3'b001,
		ST_RUN    = 3'b011,
		ST_DELAY  = 3'b010,
		ST_HICCUP = 3'b110,
		ST_LATCH  = 3'b100
	} ocotl_state_t;

	typedef struct packed {
		logic oc_byte;
		logic nota_byte;
		logic iout_word;
		logic oc_fault;
		logic oc_warn;
		logic cml_data;
	} ocotl_status_t;
endpackage

// ### src/ocotl_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - response 00/01 ignore, 10 delayed, 11 immediate
// - retry zero latches off, no restart
// - retry 1-6: hiccup, restart, latch after N
// - retry seven restarts forever
// - delay 0/1: one period, hiccup one rise
// - delay 2-4: three periods, hiccup code rises
// - delay 5-7: seven periods, hiccup code rises
// - unsupported writes flag invalid data, alert
// - warning evaluated for this phase alone
// - warning sets nota, iout, warn flags, alert
// - warning word: exponent 11110b, mantissa 10:0
// - warning accepted up to 62 A, times phases for all-phase writes
// - per-phase hardware: 8 to 62 A, 2 A
// - off-step limits round up
// - below 8 A accepted, applied as 8 A
// - restore rounds to nearest quarter ampere
// - temperature limit sets fault threshold only
// - temperature word: exponent reset 00000b
// - fault sets oc, iout, fault flags, alert
module ocotl_top (
	// clock and reset
	input  wire logic                    clk_sys_in,
	input  wire logic                    rst_b_in,
	// command port from the bus protocol layer
	input  wire logic                    cmd_valid_in,
	input  wire logic                    cmd_write_in,
	input  wire logic                    cmd_word_in,
	input  wire logic [7:0]              cmd_code_in,
	input  wire logic [15:0]             cmd_wdata_in,
	output logic      [15:0]             rd_data_out,
	output logic                         rd_valid_out,
	// phase context and store control
	input  wire logic [7:0]              phase_sel_in,
	input  wire logic [2:0]              num_phases_in,
	input  wire logic                    nvm_restore_in,
	input  wire logic                    clear_faults_in,
	// converter control
	input  wire logic                    enable_in,
	input  wire logic                    startup_ok_in,
	input  wire logic                    pwm_tick_in,
	input  wire logic [15:0]             soft_start_rise_time_in,
	input  wire logic                    oc_fault_pin_in,
	input  wire logic                    oc_warn_pin_in,
	// results
	output logic                         converter_on_out,
	output logic                         latched_off_out,
	output logic      [5:0]              hw_warn_amps_out,
	output logic      [15:0]             temp_fault_limit_out,
	output ocotl_pkg::ocotl_status_t     status_out,
	output logic                         alert_out
);
	// linear word to fixed point: value * 2^shift, rounded up or nearest
	function automatic int lin_val(input logic [15:0] w, input int shift,
		input logic nearest);
		int e;
		int m;
		e = int'($signed(w[ocotl_pkg::EXP_MSB:ocotl_pkg::EXP_LSB])) + shift;
		m = int'($signed(w[ocotl_pkg::MAN_MSB:0]));
		if (e >= 0) begin
			lin_val = (e > 18) ? 32'h7fffffff : (m <<< e);
		end else if (nearest) begin
			lin_val = (m + (1 <<< (-e - 1))) >>> (-e);
		end else begin
			lin_val = (m + (1 <<< (-e)) - 1) >>> (-e);
		end
	endfunction

	// phase count, with zero taken as a single phase
	function automatic int phases(input logic [2:0] n);
		phases = (n == 3'h0) ? 1 : int'(n);
	endfunction

	logic [1:0]                 rst_sync_r;
	logic                       rst_b;
	logic [1:0]                 oc_sync_r;
	logic [1:0]                 warn_sync_r;
	logic                       oc_prev_r;
	logic                       warn_prev_r;
	logic                       oc_lvl;
	logic                       oc_rise;
	logic                       warn_rise;

	// reset release through two stages
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_b = rst_sync_r[1];

	// comparator pins are asynchronous, edges taken after two stages
	always_ff @(posedge clk_sys_in or negedge rst_b) begin
		if (!rst_b) begin
			oc_sync_r   <= 2'h0;
			warn_sync_r <= 2'h0;
			oc_prev_r   <= 1'b0;
			warn_prev_r <= 1'b0;
		end else begin
			oc_sync_r   <= {oc_sync_r[0], oc_fault_pin_in};
			warn_sync_r <= {warn_sync_r[0], oc_warn_pin_in};
			oc_prev_r   <= oc_sync_r[1];
			warn_prev_r <= warn_sync_r[1];
		end
	end
	assign oc_lvl    = oc_sync_r[1];
	assign oc_rise   = oc_sync_r[1] & ~oc_prev_r;
	assign warn_rise = warn_sync_r[1] & ~warn_prev_r;

	// ---- command registers ----
	logic [7:0]  action_r,  action_nxt;
	logic [15:0] warn_r,    warn_nxt;
	logic [15:0] temp_r,    temp_nxt;
	logic [15:0] rdat_r,    rdat_nxt;
	logic        rvld_r,    rvld_nxt;
	logic [5:0]  hw_r,      hw_nxt;
	logic        invalid;

	always_comb begin
		int v;
		int q;
		int np;
		int a;
		logic all;
		v = 0;
		a = 0;
		np = phases(num_phases_in);
		all = (phase_sel_in == ocotl_pkg::PHASE_ALL);
		q = lin_val(warn_r, 2, 1'b0);
		action_nxt = action_r;
		warn_nxt = warn_r;
		temp_nxt = temp_r;
		rdat_nxt = rdat_r;
		rvld_nxt = 1'b0;
		invalid = 1'b0;
		if (cmd_valid_in && cmd_write_in) begin
			unique case (cmd_code_in)
				ocotl_pkg::CMD_ACTION: begin
					if (cmd_word_in) begin
						invalid = 1'b1;
					end else begin
						action_nxt = cmd_wdata_in[7:0];
					end
				end
				ocotl_pkg::CMD_WARN: begin
					v = lin_val(cmd_wdata_in, 2, 1'b0);
					if (!cmd_word_in || v < 0 ||
						v > ocotl_pkg::WARN_MAX_Q * (all ? np : 1)) begin
						invalid = 1'b1;
					end else if (all) begin
						// stack value split evenly, kept in quarter amperes
						warn_nxt = {ocotl_pkg::WARN_EXP_RST,
							11'(v / np)};
					end else begin
						warn_nxt = cmd_wdata_in;
					end
				end
				ocotl_pkg::CMD_TEMP: begin
					v = lin_val(cmd_wdata_in, 0, 1'b1);
					if (!cmd_word_in || v < ocotl_pkg::TEMP_MIN ||
						v > ocotl_pkg::TEMP_MAX) begin
						invalid = 1'b1;
					end else begin
						temp_nxt = cmd_wdata_in;
					end
				end
				default: begin
				end
			endcase
		end else if (cmd_valid_in) begin
			rvld_nxt = 1'b1;
			unique case (cmd_code_in)
				ocotl_pkg::CMD_ACTION: rdat_nxt = {8'h00, action_r};
				ocotl_pkg::CMD_WARN: begin
					rdat_nxt = all ? {ocotl_pkg::WARN_EXP_RST,
						11'(q * np)} : warn_r;
				end
				ocotl_pkg::CMD_TEMP: rdat_nxt = temp_r;
				default: begin
					rvld_nxt = 1'b0; // other commands answer elsewhere
				end
			endcase
		end
		// restore keeps only quarter-ampere steps up to 62 A
		if (nvm_restore_in) begin
			a = lin_val(warn_r, 2, 1'b1);
			a = (a < 0) ? 0 : a;
			a = (a > ocotl_pkg::WARN_MAX_Q) ? ocotl_pkg::WARN_MAX_Q : a;
			warn_nxt = {ocotl_pkg::WARN_EXP_RST, 11'(a)};
		end
		// hardware threshold: whole amperes, even steps, clamped
		a = (q + 3) >>> 2;
		a = a + (a & 1);
		a = (a < int'(ocotl_pkg::HW_MIN_A)) ?
			int'(ocotl_pkg::HW_MIN_A) : a;
		a = (a > int'(ocotl_pkg::HW_MAX_A)) ? int'(ocotl_pkg::HW_MAX_A) : a;
		hw_nxt = 6'(a);
	end

	// register bank; write and restore in one cycle, restore wins
	always_ff @(posedge clk_sys_in or negedge rst_b) begin
		if (!rst_b) begin
			action_r <= ocotl_pkg::ACTION_RST;
			warn_r   <= {ocotl_pkg::WARN_EXP_RST,
				ocotl_pkg::WARN_MAN_RST};
			temp_r   <= {ocotl_pkg::TEMP_EXP_RST,
				ocotl_pkg::TEMP_MAN_RST};
			rdat_r   <= 16'h0000;
			rvld_r   <= 1'b0;
			hw_r     <= ocotl_pkg::HW_MIN_A;
		end else begin
			action_r <= action_nxt;
			warn_r   <= warn_nxt;
			temp_r   <= temp_nxt;
			rdat_r   <= rdat_nxt;
			rvld_r   <= rvld_nxt;
			hw_r     <= hw_nxt;
		end
	end

	// ---- fault response state machine ----
	ocotl_pkg::ocotl_state_t st_r, st_nxt;
	logic [2:0]  att_r,  att_nxt;
	logic [2:0]  dly_r,  dly_nxt;
	logic [18:0] hic_r,  hic_nxt;
	logic [1:0]  resp;
	logic [2:0]  retry;
	logic [2:0]  dcode;

	assign resp  = action_r[ocotl_pkg::RESP_MSB:ocotl_pkg::RESP_LSB];
	assign retry = action_r[ocotl_pkg::RETRY_MSB:ocotl_pkg::RETRY_LSB];
	assign dcode = action_r[ocotl_pkg::DELAY_MSB:ocotl_pkg::DELAY_LSB];

	always_comb begin
		logic shut;
		logic [2:0] mult;
		shut = 1'b0;
		mult = (dcode < 3'h2) ? 3'h1 : dcode;
		st_nxt = st_r;
		att_nxt = att_r;
		dly_nxt = dly_r;
		hic_nxt = hic_r;
		unique case (st_r)
			ocotl_pkg::ST_IDLE: begin
				if (enable_in) begin
					st_nxt = ocotl_pkg::ST_START;
				end
			end
			ocotl_pkg::ST_START, ocotl_pkg::ST_RUN: begin
				if (st_r == ocotl_pkg::ST_START && startup_ok_in) begin
					st_nxt = ocotl_pkg::ST_RUN;
					att_nxt = 3'h0;
				end else if (oc_lvl && resp == ocotl_pkg::RESP_DELAYED) begin
					st_nxt = ocotl_pkg::ST_DELAY;
					dly_nxt = (dcode < 3'h2) ? ocotl_pkg::DLY_SHORT :
						(dcode < 3'h5) ? ocotl_pkg::DLY_MID :
						ocotl_pkg::DLY_LONG;
				end else if (oc_lvl && resp == ocotl_pkg::RESP_IMMED) begin
					shut = 1'b1;
				end
			end
			ocotl_pkg::ST_DELAY: begin
				if (pwm_tick_in) begin
					if (dly_r <= 3'h1) begin
						shut = 1'b1;
					end else begin
						dly_nxt = dly_r - 3'h1;
					end
				end
			end
			ocotl_pkg::ST_HICCUP: begin
				if (hic_r <= 19'h00001) begin
					st_nxt = ocotl_pkg::ST_START;
					if (retry != ocotl_pkg::RETRY_FOREVER) begin
						att_nxt = att_r + 3'h1;
					end
				end else begin
					hic_nxt = hic_r - 19'h00001;
				end
			end
			ocotl_pkg::ST_LATCH: begin
			end
			default: begin
				st_nxt = ocotl_pkg::ST_IDLE;
			end
		endcase
		// shutdown: latch off or wait one hiccup period
		if (shut) begin
			if (retry == ocotl_pkg::RETRY_NONE ||
				(retry != ocotl_pkg::RETRY_FOREVER && att_r >= retry)) begin
				st_nxt = ocotl_pkg::ST_LATCH;
			end else begin
				st_nxt = ocotl_pkg::ST_HICCUP;
				// widen before the product so long rise times do not wrap
				hic_nxt = 19'(mult) * 19'(soft_start_rise_time_in);
			end
		end
		// an off command overrides every state and forgets attempts
		if (!enable_in) begin
			st_nxt = ocotl_pkg::ST_IDLE;
			att_nxt = 3'h0;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_b) begin
		if (!rst_b) begin
			st_r  <= ocotl_pkg::ST_IDLE;
			att_r <= 3'h0;
			dly_r <= 3'h0;
			hic_r <= 19'h00000;
		end else begin
			st_r  <= st_nxt;
			att_r <= att_nxt;
			dly_r <= dly_nxt;
			hic_r <= hic_nxt;
		end
	end

	// ---- sticky status; an event in the clear cycle still sets ----
	ocotl_pkg::ocotl_status_t sts_r, sts_nxt;
	logic                     alert_r, alert_nxt;

	always_comb begin
		sts_nxt = clear_faults_in ? '0 : sts_r;
		if (oc_rise) begin
			sts_nxt.oc_byte   = 1'b1;
			sts_nxt.iout_word = 1'b1;
			sts_nxt.oc_fault  = 1'b1;
		end
		if (warn_rise) begin
			sts_nxt.nota_byte = 1'b1;
			sts_nxt.iout_word = 1'b1;
			sts_nxt.oc_warn   = 1'b1;
		end
		if (invalid) begin
			sts_nxt.cml_data = 1'b1;
		end
		alert_nxt = |sts_nxt;
	end

	always_ff @(posedge clk_sys_in or negedge rst_b) begin
		if (!rst_b) begin
			sts_r   <= '0;
			alert_r <= 1'b0;
		end else begin
			sts_r   <= sts_nxt;
			alert_r <= alert_nxt;
		end
	end

	// outputs
	assign rd_data_out          = rdat_r;
	assign rd_valid_out         = rvld_r;
	assign hw_warn_amps_out     = hw_r;
	assign temp_fault_limit_out = temp_r;
	assign status_out           = sts_r;
	assign alert_out            = alert_r;
	assign converter_on_out     = (st_r == ocotl_pkg::ST_RUN) ||
		(st_r == ocotl_pkg::ST_DELAY) || (st_r == ocotl_pkg::ST_START);
	assign latched_off_out      = (st_r == ocotl_pkg::ST_LATCH);
endmodule

// ### verif/ocotl_host.sv
`timescale 1ns/1ps
// host side of the command port, one strobe per command
module ocotl_host (
	// clock
	input	wire logic		clk_in,
	// command port towards the device
	output	logic			valid_out,
	output	logic			write_out,
	output	logic			word_out,
	output	logic [7:0]		code_out,
	output	logic [15:0]	wdata_out
);
	// idle bus before the first command
	initial begin
		{valid_out, write_out, word_out, code_out, wdata_out} = '0;
	end

	// strobe for one edge, then scramble data so stale values never match
	task automatic xfer(input logic w, input logic wd,
		input logic [7:0] c, input logic [15:0] d);
		@(posedge clk_in) #1;
		{valid_out, write_out, word_out, code_out, wdata_out} =
			{1'b1, w, wd, c, d};
		@(posedge clk_in) #1;
		valid_out = 1'b0;
		wdata_out = ~d;
	endtask
endmodule

// ### verif/ocotl_assertions.sv
`timescale 1ns/1ps
// watches command answers, fault state and status flags
module ocotl_assertions (
	// clock and reset
	input	wire logic			clk_sys_in,
	input	wire logic			rst_b_in,
	// command port
	input	wire logic			cmd_valid_in,
	input	wire logic			cmd_write_in,
	input	wire logic			cmd_word_in,
	input	wire logic [7:0]	cmd_code_in,
	input	wire logic			rd_valid_out,
	// converter side
	input	wire logic			enable_in,
	input	wire logic			converter_on_out,
	input	wire logic			latched_off_out,
	input	wire logic [5:0]	hw_warn_amps_out,
	input	wire ocotl_pkg::ocotl_status_t	status_out,
	input	wire logic			alert_out
);
	logic	own;

	// only the three codes of this block get an answer
	assign own = cmd_code_in inside {ocotl_pkg::CMD_ACTION,
		ocotl_pkg::CMD_WARN, ocotl_pkg::CMD_TEMP};

	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_b_in);

	// own-code read, and an own-code write of the wrong size
	sequence rd_req;
		cmd_valid_in && !cmd_write_in && own;
	endsequence
	sequence bad_size;
		cmd_valid_in && cmd_write_in && own &&
		(cmd_word_in == (cmd_code_in == ocotl_pkg::CMD_ACTION));
	endsequence

	rd_answer_a: assert property (
		rd_req |=> rd_valid_out) else $error("read not answered");
	rd_cause_a: assert property (
		rd_valid_out |-> $past(cmd_valid_in) && !$past(cmd_write_in))
		else $error("answer without read");
	bad_size_a: assert property (
		bad_size |=> status_out.cml_data)
		else $error("bad size not flagged");
	// alert is registered beside the flags, so both move on one edge
	alert_track_a: assert property (
		alert_out == (|status_out))
		else $error("alert does not follow status");
	latch_off_a: assert property (
		latched_off_out |-> !converter_on_out)
		else $error("on while latched");
	latch_hold_a: assert property (
		latched_off_out && enable_in |=> latched_off_out)
		else $error("latch left while enabled");
	off_cmd_a: assert property (
		!enable_in |=> !converter_on_out && !latched_off_out)
		else $error("off ignored");
	hw_step_a: assert property (
		hw_warn_amps_out inside {[8:62]} && !hw_warn_amps_out[0])
		else $error("hw step out of range");
	oc_flags_a: assert property (
		$rose(status_out.oc_fault) |->
		status_out.oc_byte && status_out.iout_word)
		else $error("fault flags incomplete");
	warn_flags_a: assert property (
		$rose(status_out.oc_warn) |->
		status_out.nota_byte && status_out.iout_word)
		else $error("warning flags incomplete");
endmodule

bind ocotl_top ocotl_assertions i_chk (.*);

// ### verif/tb_top.sv
`timescale 1ns/1ps
// bench drives the plant, host model drives commands, model checks read data
module tb_top;
	logic	clk_sys_in, rst_b_in, cmd_valid_in, cmd_write_in, cmd_word_in;
	logic	nvm_restore_in, clear_faults_in, enable_in, startup_ok_in;
	logic	pwm_tick_in, oc_fault_pin_in, oc_warn_pin_in, rd_valid_out;
	logic	converter_on_out, latched_off_out, alert_out;
	logic [1:0]		tk = 2'h0;
	logic [2:0]		num_phases_in;
	logic [5:0]		hw_warn_amps_out;
	logic [7:0]		phase_sel_in, cmd_code_in;
	logic [15:0]	soft_start_rise_time_in, cmd_wdata_in, rd_data_out;
	logic [15:0]	temp_fault_limit_out;
	ocotl_pkg::ocotl_status_t	status_out;
	int		n_mismatch, total_checks, mdl[int], q[$];

	initial begin
		clk_sys_in = 1'b0;
		forever #12.5 clk_sys_in = ~clk_sys_in;
	end

	// switching tick every fourth cycle keeps delay runs short
	always @(posedge clk_sys_in) begin
		tk <= tk + 2'h1;
		pwm_tick_in <= (tk == 2'h0);
	end

	ocotl_host i_host (.clk_in(clk_sys_in), .valid_out(cmd_valid_in),
		.write_out(cmd_write_in), .word_out(cmd_word_in),
		.code_out(cmd_code_in), .wdata_out(cmd_wdata_in));
	ocotl_top i_dut (.*);

	task automatic step(input int k);
		repeat (k) @(posedge clk_sys_in);
		#1;
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		step(1);
		s = 1'b0;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic rd(input logic [7:0] cc, input logic wd);
		i_host.xfer(1'b0, wd, cc, 16'h0000);
		chk({15'h0, rd_valid_out}, 16'h0001);
		chk(rd_data_out, 16'(mdl[cc]));
	endtask
	// refused writes leave the model alone and must raise data flag
	task automatic wr(input logic wd, input logic [7:0] cc,
		input logic [15:0] dd, input logic bad);
		i_host.xfer(1'b1, wd, cc, dd);
		if (!bad)
			mdl[cc] = dd;
		step(2);
		chk({alert_out, status_out.cml_data}, {bad, bad});
		pulse(clear_faults_in);
	endtask
	// quarter amps to hw amps: ceil, even step, floor of eight
	function automatic logic [15:0] hwx(input int m);
		int a;
		a = (m + 3) / 4;
		a = a + a % 2;
		return 16'(a < 8 ? 8 : a);
	endfunction
	// cycles from fault to latch-off, window widened by tick phase
	task automatic run(input logic [7:0] a);
		int n, r, h, s0, s1, lo;
		r = a[5:3];
		h = 8 * (a[2:0] < 3'h2 ? 1 : a[2:0]);
		s1 = a[2:0] < 3'h2 ? 1 : a[2:0] < 3'h5 ? 3 : 7;
		s0 = a[7] & a[6] ? 0 : 4 * s1 - 4;
		s1 = a[7] & a[6] ? 1 : 4 * s1 + 1;
		lo = !a[7] || r == 7 ? 300 : 2 + r * h + (r + 1) * s0;
		wr(1'b0, 8'h47, {8'h00, a}, 1'b0);
		enable_in = 1'b0;
		step(2);
		enable_in = 1'b1;
		step(1);
		pulse(startup_ok_in);
		oc_fault_pin_in = 1'b1;
		for (n = 0; latched_off_out !== 1'b1 && n < 300; n++)
			step(1);
		oc_fault_pin_in = 1'b0;
		if (lo == 300 || n > 5 + r * (h + 3) + (r + 1) * s1)
			chk(16'(n), 16'(lo));
		else
			chk(16'(n >= lo), 16'h0001);
		if (!a[7])
			chk({15'h0, converter_on_out}, 16'h0001);
		chk({10'h0, status_out}, 16'h002c);
		pulse(clear_faults_in);
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		step(8000);
		n_mismatch++;
		results;
	end

	initial begin
		{rst_b_in, nvm_restore_in, clear_faults_in, enable_in} = '0;
		{startup_ok_in, oc_fault_pin_in, oc_warn_pin_in} = '0;
		{n_mismatch, total_checks, phase_sel_in} = '0;
		num_phases_in = 3'h1;
		soft_start_rise_time_in = 16'h0008;
		void'($urandom(32'h5636));
		mdl[8'h47] = 'h00c0;
		mdl[8'h4a] = 'hf0a0;
		mdl[8'h4f] = 'h007d;
		step(16);
		rst_b_in = 1'b1;
		step(3);
		foreach (mdl[k])
			rd(8'(k), k != 'h47);
		q = '{'h0c8, 'h014, 'h0a1, 'h0f8, 'h0f9};
		repeat (4)
			q.push_back($urandom % 'hf9);
		foreach (q[i]) begin
			wr(1'b1, 8'h4a, {5'h1e, 11'(q[i])}, q[i] > 'hf8);
			// a refused value leaves the 62 A written just before it
			q[i] = q[i] > 'hf8 ? 'hf8 : q[i];
			rd(8'h4a, 1'b1);
			chk(16'(hw_warn_amps_out), hwx(q[i]));
		end
		wr(1'b0, 8'h4a, 16'h00c8, 1'b1);
		wr(1'b1, 8'h47, 16'h00c0, 1'b1);
		wr(1'b1, 8'h4f, 16'h0100, 1'b1);
		wr(1'b1, 8'h4f, 16'h0050, 1'b0);
		rd(8'h4f, 1'b1);
		chk(temp_fault_limit_out, 16'h0050);
		wr(1'b1, 8'h4a, 16'he285, 1'b0);
		pulse(nvm_restore_in);
		mdl[8'h4a] = 'hf0a1;
		rd(8'h4a, 1'b1);
		phase_sel_in = 8'hff;
		num_phases_in = 3'h2;
		wr(1'b1, 8'h4a, 16'hf1f1, 1'b1);
		wr(1'b1, 8'h4a, 16'hf1f0, 1'b0);
		rd(8'h4a, 1'b1);
		chk(16'(hw_warn_amps_out), 16'h003e);
		phase_sel_in = 8'h00;
		num_phases_in = 3'h1;
		oc_warn_pin_in = 1'b1;
		step(6);
		oc_warn_pin_in = 1'b0;
		chk({10'h0, status_out}, 16'h001a);
		chk({15'h0, alert_out}, 16'h0001);
		pulse(clear_faults_in);
		q = '{'h00, 'h40, 'hc0, 'h81, 'h83, 'h85, 'hc8, 'hd2, 'hf8};
		foreach (q[i])
			run(8'(q[i]));
		results;
	end
endmodule
